/* include/coeff_bank_pkg.sv */
// Shared constants, types and helpers for the channel B equalizer coefficient bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses; register index = byte address / 4.
package coeff_bank_pkg;

    // ==========================================
    // Filter geometry
    localparam int TAP_COUNT = 9;
    localparam int CENTRE_TAP = 4;
    localparam int OUTER_W = 12;
    localparam int OUTER_REG_W = 16;
    localparam int CENTRE_W = 18;
    localparam int CENTRE_REG_W = 24;
    localparam int ALIGN_SHIFT = CENTRE_W - OUTER_W;
    localparam int SAMPLE_W = 12;
    localparam int ACC_W = 34;
    localparam int IDX_W = 14;
    localparam int FILL_W = 4;

    // ==========================================
    // Register indices (byte address is four times the index)
    typedef logic [IDX_W-1:0] idx_type;
    localparam idx_type TAP1_IDX = 14'h0448;
    localparam idx_type TAP2_IDX = 14'h044A;
    localparam idx_type TAP3_IDX = 14'h044C;
    localparam idx_type TAP4_IDX = 14'h044E;
    localparam idx_type CENTRE_IDX = 14'h0450;
    localparam idx_type TAP6_IDX = 14'h0453;
    localparam idx_type TAP7_IDX = 14'h0455;
    localparam idx_type TAP8_IDX = 14'h0457;
    localparam idx_type TAP9_IDX = 14'h0459;
    localparam idx_type CTRL_IDX = 14'h0460;
    localparam idx_type STATUS_IDX = 14'h0461;

    // ==========================================
    // Reset values and field positions
    localparam logic [CENTRE_REG_W-1:0] COEFF_RST = 24'h000000;
    localparam logic CTRL_DUAL_RST = 1'b0;
    localparam int CTRL_DUAL_BIT = 0;
    localparam int STAT_DUAL_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_FILL_LSB = 4;
    localparam int TAP9_MASK_BIT = 11;
    localparam logic [3:0] NO_TAP = 4'hF;

    // ==========================================
    // Carriers
    typedef logic signed [SAMPLE_W-1:0] sample_type;
    typedef logic signed [CENTRE_W-1:0] coeff_type;
    typedef logic [TAP_COUNT-1:0][CENTRE_W-1:0] coeff_vec_type;
    typedef logic signed [ACC_W-1:0] acc_type;
    typedef struct packed {
        logic valid;
        sample_type data;
    } sample_beat_type;
    typedef struct packed {
        logic valid;
        acc_type data;
    } filt_beat_type;

    // ==========================================
    // Register index to tap number, NO_TAP when not a coefficient
    function automatic logic [3:0] tap_of(input idx_type idx);
        case (idx)
            TAP1_IDX: tap_of = 4'h0;
            TAP2_IDX: tap_of = 4'h1;
            TAP3_IDX: tap_of = 4'h2;
            TAP4_IDX: tap_of = 4'h3;
            CENTRE_IDX: tap_of = 4'h4;
            TAP6_IDX: tap_of = 4'h5;
            TAP7_IDX: tap_of = 4'h6;
            TAP8_IDX: tap_of = 4'h7;
            TAP9_IDX: tap_of = 4'h8;
            default: tap_of = NO_TAP;
        endcase
    endfunction

    // Stored word to aligned 18-bit coefficient; outer taps scaled up to centre precision
    function automatic coeff_type align_coeff(input logic [CENTRE_REG_W-1:0] q, input logic centre);
        if (centre) begin
            align_coeff = q[CENTRE_W-1:0];
        end else begin
            align_coeff = {q[OUTER_W-1:0], {ALIGN_SHIFT{1'b0}}};
        end
    endfunction

endpackage

/* rtl/coeff_word_reg.sv */
// One byte-lane writable coefficient register, WIDTH a multiple of eight.
// Assumes the write strobe is a one-cycle pulse from the bus slave.
`timescale 1ns/1ps
`default_nettype none
module coeff_word_reg
    import coeff_bank_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset, high
    input wire logic we_i, // Write strobe
    input wire logic [3:0] sel_i, // Byte enables
    input wire logic [31:0] wdat_i, // Write data
    output logic [WIDTH-1:0] q_o // Stored word
);
    // ==========================================
    // Storage with per-byte write, zero after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= COEFF_RST[WIDTH-1:0];
        end else if (we_i) begin
            for (int b = 0; b < WIDTH / 8; b++) begin
                if (sel_i[b]) begin
                    q_o[b*8 +: 8] <= wdat_i[b*8 +: 8];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/fir_coeff_bank_chan_b.sv */
// Channel B equalizer coefficient bank with its nine-tap filter and a Wishbone slave.
// Assumes a classic Wishbone master on the same clock and samples synchronous to clk_i.
// Operation
// - Outer tap coefficients are signed twelve-bit values in register bits 11:0.
// - Centre tap is signed eighteen bits in a 24-bit register, top six reserved.
// - Coefficients shape the channel B nine-tap filter only in dual-channel mode.
// - Tap order follows address order, first tap at the lowest address.
// - Every coefficient register, reserved bits included, resets to zero.
// - Reserved bits 15:12 of outer taps are read/write but never affect coefficients.
// - Ninth tap at 0x459 reads back its coefficient MSB as zero; writes store all.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fir_coeff_bank_chan_b
    import coeff_bank_pkg::*;
(
    input wire logic clk_i, // Clock, 125 MHz
    input wire logic rst_i, // Sync reset, high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write
    input wire logic [15:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte enables
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire sample_beat_type sample_i, // Channel B input samples
    output filt_beat_type filt_o // Filtered samples
);
    // ==========================================
    // Bus decode
    logic ack_r;
    logic req;
    logic wr_stb;
    logic rd_stb;
    idx_type idx;
    logic [3:0] hit_tap;

    // One access per request, ack a cycle later
    assign req = cyc_i & stb_i & ~ack_r;
    assign wr_stb = req & we_i;
    assign rd_stb = req & ~we_i;
    assign idx = adr_i[15:2];
    assign hit_tap = tap_of(idx);

    // ==========================================
    // Coefficient storage
    logic [CENTRE_REG_W-1:0] reg_q [TAP_COUNT];
    coeff_vec_type coeff_vec;

    // One register per tap, centre one wider
    for (genvar t = 0; t < TAP_COUNT; t++) begin : g_tap
        localparam int W = (t == CENTRE_TAP) ? CENTRE_REG_W : OUTER_REG_W;
        logic [W-1:0] q;
        coeff_word_reg #(
            .WIDTH(W)
        ) u_reg (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .we_i(wr_stb && (hit_tap == 4'(t))),
            .sel_i(sel_i),
            .wdat_i(dat_i),
            .q_o(q)
        );
        assign reg_q[t] = CENTRE_REG_W'(q);
        // Reserved bits never reach the filter
        assign coeff_vec[t] = align_coeff(reg_q[t], t == CENTRE_TAP);
    end

    // ==========================================
    // Control register: mode select
    logic dual_r;

    // Dual-channel enable written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dual_r <= CTRL_DUAL_RST;
        end else if (wr_stb && idx == CTRL_IDX && sel_i[0]) begin
            dual_r <= dat_i[CTRL_DUAL_BIT];
        end
    end

    // ==========================================
    // Filter datapath and output stage
    acc_type fir_sum;
    sample_type centre_sample;
    logic pend_r;
    logic [FILL_W-1:0] fill_r;
    logic line_full;

    fir_datapath u_fir (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .shift_i(sample_i.valid),
        .sample_i(sample_i.data),
        .coeff_i(coeff_vec),
        .sum_o(fir_sum),
        .centre_o(centre_sample)
    );

    // Output due one cycle after the line shifts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= sample_i.valid;
        end
    end

    // Equalized in dual mode, else delay-matched bypass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_o <= '0;
        end else begin
            filt_o.valid <= pend_r;
            if (pend_r) begin
                if (dual_r) begin
                    filt_o.data <= fir_sum;
                end else begin
                    filt_o.data <= acc_type'(centre_sample);
                end
            end
        end
    end

    // Samples held in the line, saturating at nine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill_r <= '0;
        end else if (sample_i.valid && !line_full) begin
            fill_r <= fill_r + 4'h1;
        end
    end

    assign line_full = (fill_r == FILL_W'(TAP_COUNT));

    // ==========================================
    // Read path
    logic [31:0] rd_data;

    // Register read mux, unmapped reads return zero
    always_comb begin
        rd_data = 32'h00000000;
        if (hit_tap != NO_TAP) begin
            rd_data = 32'(reg_q[hit_tap]);
            if (hit_tap == 4'h8) begin
                rd_data[TAP9_MASK_BIT] = 1'b0;
            end
        end else if (idx == CTRL_IDX) begin
            rd_data[CTRL_DUAL_BIT] = dual_r;
        end else if (idx == STATUS_IDX) begin
            rd_data[STAT_DUAL_BIT] = dual_r;
            rd_data[STAT_FULL_BIT] = line_full;
            rd_data[STAT_FILL_LSB +: FILL_W] = fill_r;
        end
    end

    // Acknowledge and read data, both registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_r <= req;
            if (rd_stb) begin
                dat_o <= rd_data;
            end
        end
    end

    assign ack_o = ack_r;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Full write to tap 2 shows as its 12-bit coefficient shifted up six bits
    property p_outer_signed;
        logic [11:0] v;
        (wr_stb && idx == TAP2_IDX && sel_i[1:0] == 2'h3, v = dat_i[11:0])
            |=> (coeff_type'(coeff_vec[1]) == coeff_type'({v, 6'h00}));
    endproperty
    a_outer_signed: assert property (p_outer_signed)
        else $error("outer tap coefficient not the written signed value");

    // Centre write holds 18 bits, reserved top six read back as written
    property p_centre_width;
        logic [23:0] v;
        (wr_stb && idx == CENTRE_IDX && sel_i[2:0] == 3'h7, v = dat_i[23:0])
            |=> (coeff_vec[4] == v[17:0]) && (reg_q[4] == v);
    endproperty
    a_centre_width: assert property (p_centre_width)
        else $error("centre tap register does not hold the written value");

    // Outside dual mode the output is the bypassed centre sample
    property p_mode_bypass;
        (sample_i.valid && !dual_r && !(wr_stb && idx == CTRL_IDX))
            |-> ##2 filt_o.valid && (filt_o.data == acc_type'($past(centre_sample)));
    endproperty
    a_mode_bypass: assert property (p_mode_bypass)
        else $error("bypass output wrong outside dual mode");

    // Read of the centre index returns the centre register
    property p_addr_order;
        rd_stb && idx == CENTRE_IDX |=> ack_o && (dat_o[23:0] == reg_q[4]);
    endproperty
    a_addr_order: assert property (p_addr_order)
        else $error("centre index read returned another register");

    // All taps zero right after reset release
    property p_reset_zero;
        $fell(rst_i) |-> (coeff_vec == '0) && (reg_q[8] == COEFF_RST);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("coefficient not zero after reset");

    // Lane 1 write of tap 3 stores the nibble, coefficient only from bits 11:0
    property p_reserved_inert;
        logic [7:0] v;
        (wr_stb && idx == TAP3_IDX && sel_i[1:0] == 2'h2, v = dat_i[15:8])
            |=> (reg_q[2][15:8] == v) && (coeff_vec[2] == {v[3:0], $past(reg_q[2][7:0]), 6'h00});
    endproperty
    a_reserved_inert: assert property (p_reserved_inert)
        else $error("reserved bits not stored or changed the coefficient");

    // Tap 9 reads its MSB as zero while storing it
    property p_tap9_msb;
        rd_stb && idx == TAP9_IDX |=> ack_o && !dat_o[11] && (dat_o[10:0] == reg_q[8][10:0]);
    endproperty
    a_tap9_msb: assert property (p_tap9_msb)
        else $error("ninth tap readback wrong");

    // Dual mode output equals the tap sum one cycle after the shift
    property p_fir_sum;
        (sample_i.valid && dual_r && !(wr_stb && idx == CTRL_IDX))
            ##1 (!(wr_stb && hit_tap != NO_TAP))
            |=> filt_o.valid && (filt_o.data == $past(fir_sum));
    endproperty
    a_fir_sum: assert property (p_fir_sum)
        else $error("filtered output differs from tap sum");

    // Acknowledge is a single-cycle pulse
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge held longer than one cycle");

    // Every taken request is acknowledged in the next cycle
    property p_ack_follows;
        req |=> ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("request not acknowledged in the next cycle");

    // No acknowledge without a taken request
    property p_no_stray_ack;
        !req |=> !ack_o;
    endproperty
    a_no_stray_ack: assert property (p_no_stray_ack)
        else $error("acknowledge without a request");

    // Unmapped indices read as zero
    property p_unmapped_zero;
        rd_stb && hit_tap == NO_TAP && idx != CTRL_IDX && idx != STATUS_IDX |=> dat_o == 32'h00000000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned nonzero data");

    // Outer tap reads carry nothing above bit 15
    property p_outer_read_width;
        rd_stb && hit_tap != NO_TAP && hit_tap != 4'h4 |=> dat_o[31:16] == 16'h0000;
    endproperty
    a_outer_read_width: assert property (p_outer_read_width)
        else $error("outer tap read wider than its register");

    // Centre tap reads carry nothing above bit 23
    property p_centre_read_width;
        rd_stb && idx == CENTRE_IDX |=> dat_o[31:24] == 8'h00;
    endproperty
    a_centre_read_width: assert property (p_centre_read_width)
        else $error("centre tap read wider than its register");

    // Ninth tap stores the full written word
    property p_tap9_store;
        logic [15:0] v;
        (wr_stb && idx == TAP9_IDX && sel_i[1:0] == 2'h3, v = dat_i[15:0])
            |=> (reg_q[8][15:0] == v) && (coeff_vec[8] == {v[11:0], 6'h00});
    endproperty
    a_tap9_store: assert property (p_tap9_store)
        else $error("ninth tap did not store the full word");

    // Mode bit follows a control write
    property p_mode_ctrl;
        logic v;
        (wr_stb && idx == CTRL_IDX && sel_i[0], v = dat_i[CTRL_DUAL_BIT]) |=> (dual_r == v);
    endproperty
    a_mode_ctrl: assert property (p_mode_ctrl)
        else $error("mode bit does not follow the control write");

    // Every output beat pairs with a sample two cycles earlier
    property p_valid_pair;
        filt_o.valid |-> $past(sample_i.valid, 2);
    endproperty
    a_valid_pair: assert property (p_valid_pair)
        else $error("output beat without a matching sample");

    // Outputs and state idle right after reset release
    property p_reset_regs;
        $fell(rst_i) |-> !ack_o && (dat_o == 32'h00000000) && (filt_o == '0) && !dual_r && (fill_r == '0);
    endproperty
    a_reset_regs: assert property (p_reset_regs)
        else $error("state not idle after reset");

    // Fill count saturates once the line is full
    property p_fill_sat;
        line_full && sample_i.valid |=> line_full && (fill_r == FILL_W'(TAP_COUNT));
    endproperty
    a_fill_sat: assert property (p_fill_sat)
        else $error("fill count left saturation");

endmodule
`default_nettype wire

/* rtl/fir_datapath.sv */
// Nine-tap delay line and multiply-accumulate for the equalizer.
// Assumes coefficients are already aligned to the centre tap's 18-bit precision.
`timescale 1ns/1ps
`default_nettype none
module fir_datapath
    import coeff_bank_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset, high
    input wire logic shift_i, // New sample strobe
    input wire sample_type sample_i, // New sample
    input wire coeff_vec_type coeff_i, // Aligned coefficients
    output acc_type sum_o, // Combinational tap sum
    output sample_type centre_o // Sample at the centre tap
);
    sample_type line_r [TAP_COUNT];
    acc_type acc;

    // ==========================================
    // Delay line, element 0 newest
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < TAP_COUNT; i++) begin
                line_r[i] <= '0;
            end
        end else if (shift_i) begin
            line_r[0] <= sample_i;
            for (int i = 1; i < TAP_COUNT; i++) begin
                line_r[i] <= line_r[i-1];
            end
        end
    end

    // Sum of products at full width, no overflow possible
    always_comb begin
        acc = '0;
        for (int i = 0; i < TAP_COUNT; i++) begin
            acc = acc + acc_type'(line_r[i]) * acc_type'(coeff_type'(coeff_i[i]));
        end
    end

    assign sum_o = acc;
    assign centre_o = line_r[CENTRE_TAP];
endmodule
`default_nettype wire

/* tb/fir_coeff_bank_chan_b_bench.sv */
// Self-checking bench for the channel B equalizer coefficient bank.
// Assumes a fixed two-cycle filter latency; bus answers are awaited, not counted.
`timescale 1ns/1ps
`default_nettype none
module fir_coeff_bank_chan_b_bench
    import coeff_bank_pkg::*;
();
    // ==========================================
    // Stimulus and observation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    sample_beat_type sample = '0;
    filt_beat_type filt;
    int bad_count = 0;
    int n_checks = 0;
    idx_type tap_idx [TAP_COUNT];
    logic [31:0] tap_val [TAP_COUNT];
    sample_type bp [5];

    fir_coeff_bank_chan_b dut (
        .clk_i(clk),
        .rst_i(rst),
        .cyc_i(cyc),
        .stb_i(stb),
        .we_i(we),
        .adr_i(adr),
        .sel_i(sel),
        .dat_i(wdat),
        .dat_o(rdat),
        .ack_o(ack),
        .sample_i(sample),
        .filt_o(filt)
    );

    // Free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // ==========================================
    // Verdict and compare helpers
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_sum(input acc_type got, input acc_type exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================
    // Classic Wishbone single cycle, bounded wait for ack
    task automatic wb(input logic w, input idx_type idx, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        q = 32'h00000000;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask

    // One sample in, filtered result checked two cycles later
    task automatic send(input sample_type d, input logic chk, input acc_type exp);
        @(posedge clk);
        sample <= {1'b1, d};
        @(posedge clk);
        sample <= '0;
        @(posedge clk);
        #1;
        if (chk) begin
            chk_word({31'h0, filt.valid}, 32'h00000001);
            chk_sum(filt.data, exp);
        end
    endtask

    // Sample times coefficient at centre precision
    function automatic acc_type expect_out(input longint x, input logic [31:0] q, input int k);
        longint c;
        if (k == CENTRE_TAP) begin
            c = longint'($signed(q[17:0]));
        end else begin
            c = longint'($signed(q[11:0])) * 64;
        end
        return acc_type'(x * c);
    endfunction

    // Read every tap and expect zero
    task automatic all_zero();
        logic [31:0] q;
        for (int k = 0; k < TAP_COUNT; k++) begin
            wb(1'b0, tap_idx[k], 4'hF, 32'h00000000, q);
            chk_word(q, 32'h00000000);
        end
    endtask

    // ==========================================
    // Scenarios

    // Unmapped gap between first and second tap
    task automatic t_unmapped();
        logic [31:0] q;
        wb(1'b1, 14'h0449, 4'hF, 32'hFFFFFFFF, q);
        wb(1'b0, 14'h0449, 4'hF, 32'h00000000, q);
        chk_word(q, 32'h00000000);
    endtask

    // Full-width writes, readback masked to register width, tap 9 also without bit 11
    task automatic t_write_all();
        logic [31:0] q;
        logic [31:0] mask;
        for (int k = 0; k < TAP_COUNT; k++) begin
            wb(1'b1, tap_idx[k], 4'hF, tap_val[k], q);
        end
        for (int k = 0; k < TAP_COUNT; k++) begin
            mask = (k == 4) ? 32'h00FFFFFF : ((k == 8) ? 32'h0000F7FF : 32'h0000FFFF);
            wb(1'b0, tap_idx[k], 4'hF, 32'h00000000, q);
            chk_word(q, tap_val[k] & mask);
        end
    endtask

    // Single byte lane into the reserved nibble of taps 1 and 3
    task automatic t_lane();
        logic [31:0] q;
        wb(1'b1, TAP1_IDX, 4'h2, 32'h00005500, q);
        tap_val[0] = 32'h00005501;
        wb(1'b0, TAP1_IDX, 4'hF, 32'h00000000, q);
        chk_word(q, tap_val[0]);
        wb(1'b1, TAP3_IDX, 4'h2, 32'h0000AF00, q);
        tap_val[2] = 32'h0000AFFF;
        wb(1'b0, TAP3_IDX, 4'hF, 32'h00000000, q);
        chk_word(q, tap_val[2]);
    endtask

    // Bypass: coefficients ignored outside dual mode
    task automatic t_bypass();
        for (int i = 0; i < 5; i++) begin
            send(bp[i], 1'b1, (i >= 4) ? acc_type'(longint'(bp[i - 4])) : acc_type'(0));
        end
    endtask

    // Dual mode: flush line, then impulse walks through taps in address order
    task automatic t_dual();
        logic [31:0] q;
        wb(1'b1, CTRL_IDX, 4'hF, 32'h00000001, q);
        wb(1'b0, CTRL_IDX, 4'hF, 32'h00000000, q);
        chk_word(q, 32'h00000001);
        for (int i = 0; i < TAP_COUNT; i++) begin
            send(12'h000, 1'b0, acc_type'(0));
        end
        for (int k = 0; k < TAP_COUNT; k++) begin
            send((k == 0) ? 12'hFFD : 12'h000, 1'b1, expect_out(-3, tap_val[k], k));
        end
        wb(1'b0, STATUS_IDX, 4'hF, 32'h00000000, q);
        chk_word(q, 32'h00000093);
    endtask

    // Second reset in mid-run clears every tap and the mode
    task automatic t_mid_reset();
        logic [31:0] q;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        all_zero();
        wb(1'b0, STATUS_IDX, 4'hF, 32'h00000000, q);
        chk_word(q, 32'h00000000);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        tap_idx = '{TAP1_IDX, TAP2_IDX, TAP3_IDX, TAP4_IDX, CENTRE_IDX, TAP6_IDX, TAP7_IDX, TAP8_IDX, TAP9_IDX};
        tap_val = '{32'h00000001, 32'hFFFFF005, 32'h00000FFF, 32'h000007FF, 32'hFFFFFFFE,
                    32'h00000800, 32'h00000123, 32'h00000E00, 32'h00003801};
        bp = '{12'h005, 12'hFF9, 12'h064, 12'h800, 12'h7FF};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        all_zero();
        t_unmapped();
        t_write_all();
        t_lane();
        t_bypass();
        t_dual();
        t_mid_reset();
        summarize();
    end
endmodule
`default_nettype wire
